// File: logic/usb_endpoint_data_transfer.sv
`timescale 1ns/1ps
`include "usb_ep_defs.svh"

// Summary of operation
// (R01) Isochronous IN only on ping-pong endpoints; otherwise IN tokens get NAK.
// (R02) Software checks packet-ready clear before writing IN bytes to the FIFO.
// (R03) Software sets packet-ready after loading a bank to hand it over.
// (R04) Host ACK of an IN packet sets transmit-complete, releasing the bank.
// (R05) Endpoint interrupt pending while transmit-complete is set.
// (R06) Ping-pong endpoint has two banks: one device-owned, one software-owned.
// (R07) Ping-pong: software may fill the second bank right after handing the first.
// (R08) Software arms the second bank only after transmit-complete of the first.
// (R09) No bank marked ready: IN requests answered with NAK.
// (R10) Isochronous OUT only on ping-pong endpoints; otherwise OUT gets NAK.
// (R11) Single-bank OUT: NAK while software owns FIFO, else store and ACK.
// (R12) Packet stored in bank 0 sets bank-0 full flag; interrupt pends meanwhile.
// (R13) Received byte count of the software bank is reported.
// (R14) Software reads all bytes before clearing the receive flag.
// (R15) Clearing a single-bank receive flag frees the FIFO for the next packet.
// (R16) Ping-pong OUT: first packet to bank 0, next one straight into bank 1.
// (R17) Packet stored in bank 1 sets bank-1 full flag; interrupt pends meanwhile.
// (R18) After bank 0 is cleared the next OUT packet goes to bank 0 again.
// (R19) Interrupt pends while either receive flag is set.
// (R20) Software tracks bank order itself and clears bank 0 and 1 alternately.
// (R21) FIFO contents move one byte per software read or write.
// (R22) Register side and USB side share one clock in this build.
// (R23) ACK clears the bank's packet-ready; software clears transmit-complete.
module usb_endpoint_data_transfer
  import usb_ep_pkg::*;
#(
  parameter int BANK_DEPTH = `EP_BANK_DEPTH,
  parameter int STAGE_DEPTH = `EP_STAGE_DEPTH
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PING_PONG,
  input wire logic ISO_MODE,
  input wire logic SW_WR,
  input wire logic [`EP_DATA_W-1:0] SW_WDATA,
  input wire logic SW_RD,
  input wire logic SW_SET_TX_READY,
  input wire logic SW_CLR_TX_COMPLETE,
  input wire logic SW_CLR_RX_BANK0,
  input wire logic SW_CLR_RX_BANK1,
  output logic [`EP_DATA_W-1:0] SW_RDATA,
  output logic SW_RDATA_VALID,
  output logic TX_PACKET_READY,
  output logic TX_COMPLETE,
  output logic RX_BANK0_FULL,
  output logic RX_BANK1_FULL,
  output logic [$clog2(BANK_DEPTH+1)-1:0] RX_BYTE_COUNT,
  output logic EP_IRQ_PENDING,
  input wire logic IN_TOKEN,
  input wire logic IN_READY,
  input wire logic HOST_ACK,
  output logic [`EP_DATA_W-1:0] IN_DATA,
  output logic IN_VALID,
  output logic IN_LAST,
  output logic IN_DONE,
  output logic IN_NAK,
  input wire logic OUT_START,
  input wire logic OUT_VALID,
  input wire logic [`EP_DATA_W-1:0] OUT_DATA,
  input wire logic OUT_END,
  output logic OUT_READY,
  output logic OUT_ACK,
  output logic OUT_NAK
);
  localparam int AW = $clog2(BANK_DEPTH);
  localparam int CW = $clog2(BANK_DEPTH + 1);
  localparam logic [CW-1:0] BANK_FULL = CW'(BANK_DEPTH);

  if (BANK_DEPTH < 2 || (BANK_DEPTH & (BANK_DEPTH - 1)) != 0) begin : g_chk
    $error("BANK_DEPTH must be a power of two, at least 2");
  end

  function automatic logic [AW:0] bank_addr(input logic bank, input logic [CW-1:0] off);
    bank_addr = {bank, off[AW-1:0]};
  endfunction

  // Iso traffic is refused on a single-bank endpoint
  wire iso_ok = !ISO_MODE || PING_PONG; // R01 R10

  // IN side state
  logic [1:0] tx_rdy;
  logic tx_comp;
  logic sw_in_bank;
  logic usb_in_bank;
  logic [CW-1:0] sw_wr_ptr;
  logic [CW-1:0] in_len [0:1];
  logic [CW-1:0] in_idx;
  logic in_sent;
  in_state_e in_state;

  // OUT side state
  logic [1:0] rx_full;
  logic [CW-1:0] rx_cnt [0:1];
  logic out_bank;
  logic out_active;
  logic out_ending;
  logic [CW-1:0] out_ptr;
  logic sw_rx_bank;
  logic [CW-1:0] rd_ptr;
  rd_owner_e rd_owner;

  logic [`EP_DATA_W-1:0] mem_rdata;
  stream_if #(.WIDTH(`EP_DATA_W)) stage_in ();
  stream_if #(.WIDTH(`EP_DATA_W)) stage_out ();

  // Software byte access, one byte per strobe
  wire sw_wr_go = SW_WR && !tx_rdy[sw_in_bank] && sw_wr_ptr != BANK_FULL; // R02 R21
  wire sw_rd_go = SW_RD && rx_full[sw_rx_bank] && rd_ptr < rx_cnt[sw_rx_bank]; // R14 R21
  wire in_rd_go = in_state == IN_FETCH && !sw_rd_go;

  // Software write has the port; the staging FIFO stalls behind it
  assign stage_out.ready = !sw_wr_go;
  wire drain_go = stage_out.valid && !sw_wr_go;
  wire drain_wr = drain_go && out_ptr != BANK_FULL;

  wire mem_wr_en = sw_wr_go || drain_wr;
  wire [AW:0] mem_wr_addr = sw_wr_go ? bank_addr(sw_in_bank, sw_wr_ptr)
                                     : bank_addr(out_bank, out_ptr);
  wire [`EP_DATA_W-1:0] mem_wr_data = sw_wr_go ? SW_WDATA : stage_out.data;
  wire mem_rd_en = sw_rd_go || in_rd_go;
  wire [AW:0] mem_rd_addr = sw_rd_go ? bank_addr(sw_rx_bank, rd_ptr)
                                     : bank_addr(usb_in_bank, in_idx);

  // Bytes enter the FIFO only inside an accepted OUT packet
  assign stage_in.valid = OUT_VALID && out_active;
  assign stage_in.data = OUT_DATA;

  ep_bank_mem #(.WIDTH(`EP_DATA_W), .DEPTH(2 * BANK_DEPTH)) u_mem ( // R06
    .clk(CLK),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rdata)
  );

  ep_stream_fifo #(.WIDTH(`EP_DATA_W), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk(CLK),
    .rst_n(NRST),
    .wr(stage_in.snk),
    .rd(stage_out.src)
  );
  // IN control decode
  wire in_idle = in_state == IN_IDLE;
  wire tok_go = IN_TOKEN && in_idle;
  wire tok_send = tok_go && tx_rdy[usb_in_bank] && iso_ok;
  wire tok_zlp = tok_send && in_len[usb_in_bank] == '0;
  wire in_last_byte = in_idx == in_len[usb_in_bank] - CW'(1);
  wire in_end = in_state == IN_PRESENT && IN_READY && IN_LAST;
  wire ack_go = HOST_ACK && in_idle && in_sent;
  wire arm_go = SW_SET_TX_READY && !tx_rdy[sw_in_bank];
  // OUT control decode
  wire out_go = OUT_START && !out_active;
  wire out_take = out_go && iso_ok && !rx_full[out_bank];
  wire out_store = out_ending && !stage_out.valid;
  logic [1:0] next_tx_rdy;
  logic next_tx_comp;
  logic [1:0] next_rx_full;
  always_comb begin
    next_tx_rdy = tx_rdy;
    if (ack_go) next_tx_rdy[usb_in_bank] = 1'b0; // R23
    if (arm_go) next_tx_rdy[sw_in_bank] = 1'b1; // R03
  end
  // A new ACK wins over a software clear in the same cycle
  assign next_tx_comp = ack_go || (tx_comp && !SW_CLR_TX_COMPLETE); // R04 R23
  // Store comes last so a set beats a clear in the same cycle
  always_comb begin
    next_rx_full = rx_full;
    if (SW_CLR_RX_BANK0) next_rx_full[0] = 1'b0; // R15
    if (SW_CLR_RX_BANK1) next_rx_full[1] = 1'b0;
    if (out_store) next_rx_full[out_bank] = 1'b1; // R12 R17
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_rdy <= `EP_TX_READY_RST;
      tx_comp <= `EP_TX_COMPLETE_RST;
      rx_full <= `EP_RX_FULL_RST;
    end else begin
      tx_rdy <= next_tx_rdy;
      tx_comp <= next_tx_comp;
      rx_full <= next_rx_full;
    end
  end

  // Software fill side of the IN banks
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_in_bank <= 1'b0;
      sw_wr_ptr <= '0;
      in_len[0] <= '0;
      in_len[1] <= '0;
    end else if (arm_go) begin
      in_len[sw_in_bank] <= sw_wr_ptr;
      sw_wr_ptr <= '0;
      sw_in_bank <= PING_PONG ? !sw_in_bank : 1'b0; // R07
    end else if (sw_wr_go) begin
      sw_wr_ptr <= sw_wr_ptr + CW'(1);
    end
  end

  // Device side of the IN banks: stream, then wait for the handshake
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      in_state <= IN_IDLE;
      in_idx <= '0;
      in_sent <= 1'b0;
      usb_in_bank <= 1'b0;
    end else begin
      case (in_state)
        IN_IDLE: begin
          if (tok_send && !tok_zlp) begin
            in_idx <= '0;
            in_state <= IN_FETCH;
          end
          if (tok_zlp) in_sent <= 1'b1;
          if (ack_go) begin
            in_sent <= 1'b0;
            usb_in_bank <= PING_PONG ? !usb_in_bank : 1'b0; // R06
          end
        end
        IN_FETCH: begin
          if (in_rd_go) in_state <= IN_WAIT;
        end
        IN_WAIT: in_state <= IN_PRESENT;
        IN_PRESENT: begin
          if (IN_READY) begin
            in_idx <= in_idx + CW'(1);
            in_state <= IN_LAST ? IN_IDLE : IN_FETCH;
            in_sent <= in_sent || IN_LAST;
          end
        end
        default: in_state <= IN_IDLE;
      endcase
    end
  end
  // Byte presented to the bus engine
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IN_DATA <= '0;
      IN_VALID <= 1'b0;
      IN_LAST <= 1'b0;
      IN_DONE <= 1'b0;
      IN_NAK <= 1'b0;
    end else begin
      if (in_state == IN_WAIT) begin
        IN_DATA <= mem_rdata;
        IN_VALID <= 1'b1;
        IN_LAST <= in_last_byte;
      end else if (in_state == IN_PRESENT && IN_READY) begin
        IN_VALID <= 1'b0;
        IN_LAST <= 1'b0;
      end
      IN_DONE <= in_end || tok_zlp;
      IN_NAK <= tok_go && !tok_send; // R09 R01
    end
  end
  // OUT packet reception into the free bank
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_bank <= 1'b0;
      out_active <= 1'b0;
      out_ending <= 1'b0;
      out_ptr <= '0;
      rx_cnt[0] <= '0;
      rx_cnt[1] <= '0;
      OUT_ACK <= 1'b0;
      OUT_NAK <= 1'b0;
    end else begin
      OUT_ACK <= out_store; // R11
      OUT_NAK <= out_go && !out_take; // R11 R10
      if (out_take) begin
        out_active <= 1'b1;
        out_ptr <= '0;
      end else if (drain_wr) begin
        out_ptr <= out_ptr + CW'(1);
      end
      if (OUT_END && out_active) out_ending <= 1'b1;
      // Flag set only once the staging FIFO has fully drained
      if (out_store) begin
        rx_cnt[out_bank] <= out_ptr;
        out_active <= 1'b0;
        out_ending <= 1'b0;
        out_bank <= PING_PONG ? !out_bank : 1'b0; // R16 R18
      end
    end
  end

  // Software read side of the OUT banks
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_rx_bank <= 1'b0;
      rd_ptr <= '0;
    end else if (SW_CLR_RX_BANK0 || SW_CLR_RX_BANK1) begin
      // Order is not tracked here; software alternates the clears
      rd_ptr <= '0;
      sw_rx_bank <= PING_PONG ? SW_CLR_RX_BANK0 : 1'b0; // R20
    end else if (sw_rd_go) begin
      rd_ptr <= rd_ptr + CW'(1);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_owner <= RD_NONE;
      SW_RDATA <= '0;
      SW_RDATA_VALID <= 1'b0;
    end else begin
      rd_owner <= sw_rd_go ? RD_SOFT : (in_rd_go ? RD_USB : RD_NONE);
      SW_RDATA_VALID <= rd_owner == RD_SOFT;
      if (rd_owner == RD_SOFT) SW_RDATA <= mem_rdata;
    end
  end

  // Status outputs, one cycle behind the flags; both share CLK here
  always_ff @(posedge CLK or negedge NRST) begin // R22
    if (!NRST) begin
      TX_PACKET_READY <= 1'b0;
      TX_COMPLETE <= 1'b0;
      RX_BANK0_FULL <= 1'b0;
      RX_BANK1_FULL <= 1'b0;
      RX_BYTE_COUNT <= '0;
      EP_IRQ_PENDING <= 1'b0;
      OUT_READY <= 1'b0;
    end else begin
      TX_PACKET_READY <= tx_rdy[sw_in_bank]; // R08
      TX_COMPLETE <= tx_comp;
      RX_BANK0_FULL <= rx_full[0];
      RX_BANK1_FULL <= rx_full[1];
      RX_BYTE_COUNT <= rx_full[sw_rx_bank] ? rx_cnt[sw_rx_bank] : '0; // R13
      EP_IRQ_PENDING <= tx_comp || rx_full[0] || rx_full[1]; // R05 R19
      OUT_READY <= stage_in.ready && out_active;
    end
  end
endmodule

// File: logic/usb_ep_defs.svh
`ifndef USB_EP_DEFS_SVH
`define USB_EP_DEFS_SVH

// Clock rate of the endpoint logic
`define EP_CLK_HZ 25000000

// Bytes per FIFO bank and depth of the OUT staging FIFO
`define EP_BANK_DEPTH 64
`define EP_STAGE_DEPTH 16
`define EP_DATA_W 8

// Reset values of the endpoint flags
`define EP_TX_READY_RST 2'b00
`define EP_TX_COMPLETE_RST 1'b0
`define EP_RX_FULL_RST 2'b00

`endif

// File: logic/usb_ep_pkg.sv
package usb_ep_pkg;

  typedef enum {IN_IDLE, IN_FETCH, IN_WAIT, IN_PRESENT} in_state_e;

  typedef enum {RD_NONE, RD_SOFT, RD_USB} rd_owner_e;

endpackage

// File: logic/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: logic/ep_bank_mem.sv
`timescale 1ns/1ps
module ep_bank_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  // No reset: plain storage, read data held until the next read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: logic/ep_stream_fifo.sv
`timescale 1ns/1ps
module ep_stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("ep_stream_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  wire push = wr.valid & wr.ready;
  wire pop = rd.valid & rd.ready;

  assign next_cnt = cnt + CW'(push) - CW'(pop);
  assign rd.data = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= wr.data;
    end
  end

  // Flags registered from the next count so both stay honest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      rd.valid <= 1'b0;
      wr.ready <= 1'b0;
    end else begin
      wp <= wp + PW'(push);
      rp <= rp + PW'(pop);
      cnt <= next_cnt;
      rd.valid <= next_cnt != '0;
      wr.ready <= next_cnt != FULL_CNT;
    end
  end
endmodule

// File: bench/usb_ep_properties.sv
`timescale 1ns/1ps
module usb_ep_checker (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PING_PONG,
  input wire logic ISO_MODE,
  input wire logic SW_RD,
  input wire logic SW_RDATA_VALID,
  input wire logic TX_PACKET_READY,
  input wire logic TX_COMPLETE,
  input wire logic RX_BANK0_FULL,
  input wire logic RX_BANK1_FULL,
  input wire logic EP_IRQ_PENDING,
  input wire logic IN_TOKEN,
  input wire logic HOST_ACK,
  input wire logic IN_VALID,
  input wire logic IN_LAST,
  input wire logic IN_DONE,
  input wire logic OUT_START,
  input wire logic OUT_ACK,
  input wire logic OUT_NAK,
  input wire logic IN_NAK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire rx = RX_BANK0_FULL | RX_BANK1_FULL;
  // Pending is registered in the same cycle as the flags; the check still asks for two flagged cycles
  property p_irq_tx; TX_COMPLETE && $past(TX_COMPLETE) |-> EP_IRQ_PENDING; endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("irq low on tx");
  property p_irq_rx; rx && $past(rx) |-> EP_IRQ_PENDING; endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("irq low on rx");
  property p_tx_cause; $rose(TX_COMPLETE) |-> $past(HOST_ACK) || $past(HOST_ACK, 2); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx done w/o ack");
  property p_iso_in; ISO_MODE && !PING_PONG && IN_TOKEN |-> ##[1:2] IN_NAK; endproperty
  a_iso_in: assert property (p_iso_in) else $error("iso in not refused");
  property p_armed_in;
    !PING_PONG && !ISO_MODE && TX_PACKET_READY && IN_TOKEN |-> ##[1:5] (IN_VALID || IN_DONE);
  endproperty
  a_armed_in: assert property (p_armed_in) else $error("armed bank not sent");
  property p_iso_out; ISO_MODE && !PING_PONG && OUT_START |-> ##[1:2] OUT_NAK; endproperty
  a_iso_out: assert property (p_iso_out) else $error("iso out not refused");
  property p_full_out; !PING_PONG && RX_BANK0_FULL && OUT_START |-> ##[1:2] OUT_NAK; endproperty
  a_full_out: assert property (p_full_out) else $error("full bank not refused");
  property p_rd_lat; SW_RDATA_VALID |-> $past(SW_RD, 2); endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data latency");
  property p_last_valid; IN_LAST |-> IN_VALID; endproperty
  a_last_valid: assert property (p_last_valid) else $error("last flag without byte");
  c_in: cover property (IN_DONE);
  c_pp_out: cover property (OUT_ACK && PING_PONG);
  c_both: cover property (RX_BANK0_FULL && RX_BANK1_FULL);
endmodule
bind usb_endpoint_data_transfer usb_ep_checker usb_ep_checker_i (.*);

// File: bench/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input wire logic CLK,
  output logic IN_TOKEN,
  output logic IN_READY,
  output logic HOST_ACK,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_VALID,
  input wire logic IN_DONE,
  input wire logic IN_NAK,
  output logic OUT_START,
  output logic OUT_VALID,
  output logic [7:0] OUT_DATA,
  output logic OUT_END,
  input wire logic OUT_READY,
  input wire logic OUT_ACK,
  input wire logic OUT_NAK
);
  logic slow;
  initial begin
    slow = 0;
    {IN_TOKEN, IN_READY, HOST_ACK, OUT_START, OUT_VALID, OUT_END} = '0;
    OUT_DATA = 8'h00;
  end
  task automatic in_txn(output logic [7:0] got[$], output logic nak);
    int t;
    got = {};
    @(negedge CLK) IN_TOKEN = 1;
    @(negedge CLK) IN_TOKEN = 0;
    for (t = 0; t < 300; t++) begin
      IN_READY = !slow || t[0];
      if (IN_VALID && IN_READY) got.push_back(IN_DATA);
      if (IN_NAK || IN_DONE) break;
      @(negedge CLK);
    end
    nak = IN_NAK;
    IN_READY = 0;
  endtask
  task automatic send_ack;
    @(negedge CLK) HOST_ACK = 1;
    @(negedge CLK) HOST_ACK = 0;
  endtask
  task automatic out_txn(input logic [7:0] d[$], output logic ack, output logic nak);
    int t;
    ack = 0;
    nak = 0;
    @(negedge CLK) OUT_START = 1;
    @(negedge CLK) OUT_START = 0;
    for (t = 0; t < 4 && !OUT_READY && !nak; t++) begin
      nak = OUT_NAK;
      if (!nak) @(negedge CLK);
    end
    if (nak || !OUT_READY) return;
    foreach (d[i]) begin
      // Idle gaps keep the byte path honest; idle data is scrambled
      if (slow && i > 0) begin
        OUT_VALID = 0;
        OUT_DATA = ~OUT_DATA;
        @(negedge CLK);
      end
      OUT_VALID = 1;
      OUT_DATA = d[i];
      while (!OUT_READY) @(negedge CLK);
      @(negedge CLK);
    end
    OUT_VALID = 0;
    OUT_DATA = ~OUT_DATA;
    OUT_END = 1;
    @(negedge CLK) OUT_END = 0;
    for (t = 0; t < 80 && !ack; t++) begin
      ack = OUT_ACK;
      if (!ack) @(negedge CLK);
    end
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int BD = 8;
  logic CLK, NRST, PING_PONG, ISO_MODE, SW_WR, SW_RD, SW_SET_TX_READY, SW_CLR_TX_COMPLETE;
  logic SW_CLR_RX_BANK0, SW_CLR_RX_BANK1, SW_RDATA_VALID, TX_PACKET_READY, TX_COMPLETE;
  logic RX_BANK0_FULL, RX_BANK1_FULL, EP_IRQ_PENDING, IN_TOKEN, IN_READY, HOST_ACK;
  logic IN_VALID, IN_LAST, IN_DONE, IN_NAK, OUT_START, OUT_VALID, OUT_END, OUT_READY;
  logic OUT_ACK, OUT_NAK, ack, nak;
  logic [7:0] SW_WDATA, SW_RDATA, IN_DATA, OUT_DATA;
  logic [$clog2(BD+1)-1:0] RX_BYTE_COUNT;
  logic [7:0] qa[$], qb[$], qc[$], got[$];
  int n_mismatch, checks, seed, k, n;
  usb_endpoint_data_transfer #(.BANK_DEPTH(BD)) usb_endpoint_data_transfer_i (.*);
  usb_host_model usb_host_model_i (.*);
  initial begin
    CLK = 0;
    forever #20 CLK = ~CLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Few hundred cycles needed; this is about 50000
  initial begin
    #2000000;
    n_mismatch++;
    final_report;
  end
  task automatic pulse(ref logic s);
    @(negedge CLK) s = 1;
    @(negedge CLK) s = 0;
  endtask
  task automatic st(input logic [4:0] e);
    repeat (3) @(negedge CLK);
    check({TX_PACKET_READY, TX_COMPLETE, RX_BANK0_FULL, RX_BANK1_FULL, EP_IRQ_PENDING}, e);
  endtask
  function automatic int rlen();
    return 1 + ($unsigned($random(seed)) % (BD - 1));
  endfunction
  task automatic mkq(input int c, output logic [7:0] e[$]);
    e = {};
    repeat (c) e.push_back(8'($random(seed)));
  endtask
  task automatic fill(input logic [7:0] e[$]);
    foreach (e[i]) begin
      @(negedge CLK);
      SW_WR = 1;
      SW_WDATA = e[i];
    end
    @(negedge CLK) SW_WR = 0;
  endtask
  task automatic drain(input int c, output logic [7:0] a[$]);
    int t;
    a = {};
    repeat (c) begin
      pulse(SW_RD);
      for (t = 0; t < 4 && !SW_RDATA_VALID; t++) @(negedge CLK);
      if (SW_RDATA_VALID === 1'b1) a.push_back(SW_RDATA);
    end
  endtask
  task automatic cmp_q(input logic [7:0] a[$], input logic [7:0] e[$]);
    check(a.size(), e.size());
    foreach (a[i]) check(a[i], e[i]);
  endtask
  initial begin
    seed = 32'hf481fb73;
    {NRST, PING_PONG, ISO_MODE, SW_WR, SW_RD, SW_SET_TX_READY, SW_CLR_TX_COMPLETE} = '0;
    {SW_CLR_RX_BANK0, SW_CLR_RX_BANK1, n_mismatch, checks} = '0;
    SW_WDATA = 8'h00;
    repeat (2) @(negedge CLK);
    NRST = 1;
    st(5'b00000);
    usb_host_model_i.in_txn(got, nak);
    check(nak, 1);
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? BD : rlen();
      mkq(n, qa);
      fill(qa);
      pulse(SW_SET_TX_READY);
      st(5'b10000);
      if (k == 1) begin
        ISO_MODE = 1;
        usb_host_model_i.in_txn(got, nak);
        check(nak, 1);
        ISO_MODE = 0;
      end
      usb_host_model_i.in_txn(got, nak);
      check(nak, 0);
      cmp_q(got, qa);
      usb_host_model_i.send_ack;
      st(5'b01001);
      pulse(SW_CLR_TX_COMPLETE);
      st(5'b00000);
    end
    usb_host_model_i.slow = 1;
    PING_PONG = 1;
    ISO_MODE = 1;
    mkq(rlen(), qa);
    mkq(rlen(), qb);
    fill(qa);
    pulse(SW_SET_TX_READY);
    fill(qb);
    st(5'b00000);
    usb_host_model_i.in_txn(got, nak);
    cmp_q(got, qa);
    usb_host_model_i.send_ack;
    st(5'b01001);
    pulse(SW_CLR_TX_COMPLETE);
    pulse(SW_SET_TX_READY);
    usb_host_model_i.in_txn(got, nak);
    cmp_q(got, qb);
    usb_host_model_i.send_ack;
    pulse(SW_CLR_TX_COMPLETE);
    usb_host_model_i.in_txn(got, nak);
    check(nak, 1);
    PING_PONG = 0;
    ISO_MODE = 0;
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? BD : rlen();
      mkq(n, qa);
      usb_host_model_i.out_txn(qa, ack, nak);
      check({ack, nak}, 2'b10);
      st(5'b00101);
      check(RX_BYTE_COUNT, n);
      usb_host_model_i.out_txn(qa, ack, nak);
      check({ack, nak}, 2'b01);
      drain(n, got);
      cmp_q(got, qa);
      pulse(SW_CLR_RX_BANK0);
      st(5'b00000);
    end
    ISO_MODE = 1;
    usb_host_model_i.out_txn(qa, ack, nak);
    check(nak, 1);
    PING_PONG = 1;
    mkq(rlen(), qa);
    mkq(rlen(), qb);
    mkq(rlen(), qc);
    usb_host_model_i.out_txn(qa, ack, nak);
    usb_host_model_i.out_txn(qb, ack, nak);
    check(ack, 1);
    st(5'b00111);
    check(RX_BYTE_COUNT, qa.size());
    usb_host_model_i.out_txn(qc, ack, nak);
    check(nak, 1);
    drain(qa.size(), got);
    cmp_q(got, qa);
    pulse(SW_CLR_RX_BANK0);
    st(5'b00011);
    usb_host_model_i.out_txn(qc, ack, nak);
    st(5'b00111);
    drain(qb.size(), got);
    cmp_q(got, qb);
    pulse(SW_CLR_RX_BANK1);
    st(5'b00101);
    drain(qc.size(), got);
    cmp_q(got, qc);
    pulse(SW_CLR_RX_BANK0);
    st(5'b00000);
    final_report;
  end
endmodule
